// ===== logic/fsp_pkg.sv
package fsp_pkg;
    // Register indexes; the byte address on APB is four times the index
    localparam logic [15:0] FSP_CTRL_IDX   = 16'hC070;
    localparam logic [15:0] FSP_BAUD_IDX   = 16'hC072;
    localparam logic [15:0] FSP_GAP_IDX    = 16'hC074;
    localparam logic [15:0] FSP_DATA_IDX   = 16'hC076;
    localparam logic [15:0] FSP_RXBASE_IDX = 16'hC078;
    localparam logic [15:0] FSP_RXCNT_IDX  = 16'hC07A;
    localparam logic [15:0] FSP_TXBASE_IDX = 16'hC07C;
    localparam logic [15:0] FSP_TXCNT_IDX  = 16'hC07E;

    // Control register bit positions
    localparam int FSP_TXDONE_BIT  = 7;
    localparam int FSP_RXDONE_BIT  = 6;
    localparam int FSP_ONESTOP_BIT = 5;
    localparam int FSP_TXRDY_BIT   = 4;
    localparam int FSP_RXRDY_BIT   = 0;

    // Reset values and fixed counts
    localparam logic [7:0]  FSP_GAP_RST  = 8'h09;
    localparam logic [12:0] FSP_BAUD_RST = 13'h0017;
    localparam logic [15:0] FSP_ADDR_RST = 16'h0000;
    localparam logic [9:0]  FSP_CNT_RST  = 10'h000;
    localparam logic [9:0]  FSP_CNT_TERM = 10'h3FF;
    localparam logic [7:0]  FSP_GAP_BIAS = 8'h07;
    localparam logic [2:0]  FSP_LAST_BIT = 3'h7;
    localparam logic [7:0]  FSP_STOP_ONE = 8'h01;
    localparam logic [7:0]  FSP_STOP_TWO = 8'h02;

    typedef enum logic [2:0] {
        TX_IDLE, TX_FETCH, TX_WAIT, TX_LOAD, TX_START, TX_DATA, TX_STOP
    } fsp_tx_st_type;

    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} fsp_rx_st_type;

    typedef struct packed {
        logic        req;
        logic        we;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } fsp_mem_type;

    typedef struct packed {
        logic          phase;
        logic [15:0]   prdata;
        logic          perr;
        logic          one_stop;
        logic          tx_done;
        logic          rx_done;
        logic          rx_rdy;
        logic [12:0]   baud;
        logic [7:0]    gap;
        logic [7:0]    rx_data;
        logic [15:0]   rx_base;
        logic [15:0]   rx_ptr;
        logic [9:0]    rx_cnt;
        logic          rx_blk;
        logic [15:0]   tx_base;
        logic [15:0]   tx_ptr;
        logic [9:0]    tx_cnt;
        logic          tx_blk;
        fsp_tx_st_type tx_st;
        logic [7:0]    tx_shift;
        logic [7:0]    tx_bits;
        logic [12:0]   tx_tmr;
        logic          tx_line;
        fsp_rx_st_type rx_st;
        logic [7:0]    rx_shift;
        logic [2:0]    rx_bits;
        logic [12:0]   rx_tmr;
        logic          rx_s1;
        logic          rx_s2;
        fsp_mem_type   mem;
    } fsp_state_type;
endpackage : fsp_pkg

// ===== logic/fsp_serial_port.sv
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ps
module fsp_serial_port
    import fsp_pkg::*;
(
    input  wire logic        pclk,     // APB and serial clock
    input  wire logic        presetn,  // Async reset, active low
    input  wire logic        ce,       // Clock enable, freezes all state
    input  wire logic        psel,     // APB select
    input  wire logic        penable,  // APB access phase
    input  wire logic        pwrite,   // APB direction
    input  wire logic [31:0] paddr,    // APB byte address
    input  wire logic [31:0] pwdata,   // APB write data
    output logic      [31:0] prdata,   // APB read data
    output logic             pready,   // APB ready
    output logic             pslverr,  // APB error, unmapped address
    input  wire logic        rxd,      // Serial receive pin
    output logic             txd,      // Serial transmit pin
    output fsp_mem_type      mem_o,    // Memory request to on-chip RAM
    input  wire logic [7:0]  mem_rdata // Read data, valid cycle after req
);

    fsp_state_type s_ff;
    fsp_state_type nxt_s;

    function automatic logic fsp_hit(input logic [31:0] a, input logic [15:0] idx);
        fsp_hit = (a == {14'h0000, idx, 2'b00});
    endfunction : fsp_hit

    // Reload on the tick, so each bit lasts divisor plus one clocks
    function automatic logic [12:0] fsp_tmr_next(input logic [12:0] tmr,
                                                 input logic [12:0] baud);
        fsp_tmr_next = (tmr == 13'h0000) ? baud : tmr - 13'h0001;
    endfunction : fsp_tmr_next

    logic        wr;
    logic        rd;
    logic        tx_tick;
    logic        rx_tick;
    logic [7:0]  gap_bits;

    // Read data is captured one cycle ahead so prdata comes from a flop
    assign pready  = psel & penable & ce & s_ff.phase;
    assign prdata  = {16'h0000, s_ff.prdata};
    assign pslverr = s_ff.perr;
    assign txd     = s_ff.tx_line;
    assign mem_o   = s_ff.mem;

    always_comb begin
        nxt_s          = s_ff;
        // Memory strobes are single-cycle pulses
        nxt_s.mem.req  = 1'b0;
        nxt_s.mem.we   = 1'b0;
        wr             = pready & pwrite;
        rd             = pready & ~pwrite;
        tx_tick        = (s_ff.tx_tmr == 13'h0000);
        rx_tick        = (s_ff.rx_tmr == 13'h0000);
        gap_bits       = s_ff.gap - FSP_GAP_BIAS;
        // A gap of seven or less would wrap the stop count into 249 to 256 stop bits
        if (s_ff.gap <= FSP_GAP_BIAS) begin
            gap_bits = 8'h01;
        end

        // APB access phase tracking
        nxt_s.phase = psel & ~(penable & s_ff.phase);
        if (psel & ~s_ff.phase) begin
            nxt_s.perr   = 1'b0;
            nxt_s.prdata = 16'h0000;
            if (fsp_hit(paddr, FSP_CTRL_IDX)) begin
                nxt_s.prdata[FSP_TXDONE_BIT]  = s_ff.tx_done;
                nxt_s.prdata[FSP_RXDONE_BIT]  = s_ff.rx_done;
                nxt_s.prdata[FSP_ONESTOP_BIT] = s_ff.one_stop;
                // Ready stays low for the whole block, not just one frame
                nxt_s.prdata[FSP_TXRDY_BIT]   = (s_ff.tx_st == TX_IDLE) & ~s_ff.tx_blk;
                nxt_s.prdata[FSP_RXRDY_BIT]   = s_ff.rx_rdy;
            end else if (fsp_hit(paddr, FSP_BAUD_IDX)) begin
                nxt_s.prdata[12:0] = s_ff.baud;
            end else if (fsp_hit(paddr, FSP_GAP_IDX)) begin
                nxt_s.prdata[7:0] = s_ff.gap;
            end else if (fsp_hit(paddr, FSP_DATA_IDX)) begin
                nxt_s.prdata[7:0] = s_ff.rx_data;
            end else if (fsp_hit(paddr, FSP_RXBASE_IDX)) begin
                nxt_s.prdata = s_ff.rx_base;
            end else if (fsp_hit(paddr, FSP_RXCNT_IDX)) begin
                nxt_s.prdata[9:0] = s_ff.rx_cnt;
            end else if (fsp_hit(paddr, FSP_TXBASE_IDX)) begin
                nxt_s.prdata = s_ff.tx_base;
            end else if (fsp_hit(paddr, FSP_TXCNT_IDX)) begin
                nxt_s.prdata[9:0] = s_ff.tx_cnt;
            end else begin
                nxt_s.perr = 1'b1;
            end
        end

        // Reading the data register consumes the byte
        if (rd && fsp_hit(paddr, FSP_DATA_IDX)) begin
            nxt_s.rx_rdy = 1'b0;
        end

        // Register writes; hardware sets below override these clears
        if (wr) begin
            if (fsp_hit(paddr, FSP_CTRL_IDX)) begin
                nxt_s.one_stop = pwdata[FSP_ONESTOP_BIT];
                if (pwdata[FSP_TXDONE_BIT]) begin
                    nxt_s.tx_done = 1'b0;
                end
                if (pwdata[FSP_RXDONE_BIT]) begin
                    nxt_s.rx_done = 1'b0;
                end
            end
            if (fsp_hit(paddr, FSP_BAUD_IDX)) begin
                nxt_s.baud = pwdata[12:0];
            end
            if (fsp_hit(paddr, FSP_GAP_IDX)) begin
                nxt_s.gap = pwdata[7:0];
            end
            // Writes while busy are dropped to protect the frame on the line
            if (fsp_hit(paddr, FSP_DATA_IDX) && s_ff.tx_st == TX_IDLE && !s_ff.tx_blk) begin
                nxt_s.tx_shift = pwdata[7:0];
                nxt_s.tx_st    = TX_START;
                nxt_s.tx_tmr   = s_ff.baud;
            end
            if (fsp_hit(paddr, FSP_RXBASE_IDX)) begin
                nxt_s.rx_base = pwdata[15:0];
            end
            // Rewrite mid-transfer restarts at the base, no resume
            if (fsp_hit(paddr, FSP_RXCNT_IDX)) begin
                nxt_s.rx_cnt = pwdata[9:0];
                nxt_s.rx_ptr = s_ff.rx_base;
                nxt_s.rx_blk = 1'b1;
            end
            if (fsp_hit(paddr, FSP_TXBASE_IDX)) begin
                nxt_s.tx_base = pwdata[15:0];
            end
            if (fsp_hit(paddr, FSP_TXCNT_IDX)) begin
                nxt_s.tx_cnt = pwdata[9:0];
                nxt_s.tx_ptr = s_ff.tx_base;
                nxt_s.tx_blk = 1'b1;
            end
        end

        // Receiver, sampling mid-bit on the synchronised line
        nxt_s.rx_s1 = rxd;
        nxt_s.rx_s2 = s_ff.rx_s1;
        if (s_ff.rx_st != RX_IDLE) begin
            nxt_s.rx_tmr = fsp_tmr_next(s_ff.rx_tmr, s_ff.baud);
        end
        unique case (s_ff.rx_st)
            RX_IDLE: begin
                // Synced line resets high, so no false start after reset
                if (!s_ff.rx_s2) begin
                    nxt_s.rx_st  = RX_START;
                    nxt_s.rx_tmr = {1'b0, s_ff.baud[12:1]};
                end
            end
            RX_START: begin
                if (rx_tick) begin
                    nxt_s.rx_st   = s_ff.rx_s2 ? RX_IDLE : RX_DATA;
                    nxt_s.rx_bits = 3'h0;
                end
            end
            RX_DATA: begin
                if (rx_tick) begin
                    nxt_s.rx_shift = {s_ff.rx_s2, s_ff.rx_shift[7:1]};
                    nxt_s.rx_bits  = s_ff.rx_bits + 3'h1;
                    if (s_ff.rx_bits == FSP_LAST_BIT) begin
                        nxt_s.rx_st = RX_STOP;
                    end
                end
            end
            RX_STOP: begin
                if (rx_tick) begin
                    nxt_s.rx_st = RX_IDLE;
                    // A missing stop bit discards the byte
                    if (s_ff.rx_s2 && s_ff.rx_blk) begin
                        nxt_s.mem.req   = 1'b1;
                        nxt_s.mem.we    = 1'b1;
                        nxt_s.mem.addr  = s_ff.rx_ptr;
                        nxt_s.mem.wdata = s_ff.rx_shift;
                        nxt_s.rx_ptr    = s_ff.rx_ptr + 16'h0001;
                        nxt_s.rx_cnt    = s_ff.rx_cnt - 10'h001;
                        if (s_ff.rx_cnt == FSP_CNT_RST) begin
                            nxt_s.rx_blk  = 1'b0;
                            nxt_s.rx_done = 1'b1;
                        end
                    end else if (s_ff.rx_s2) begin
                        nxt_s.rx_data = s_ff.rx_shift;
                        nxt_s.rx_rdy  = 1'b1;
                    end
                end
            end
        endcase

        // Transmitter
        if (s_ff.tx_st == TX_START || s_ff.tx_st == TX_DATA || s_ff.tx_st == TX_STOP) begin
            nxt_s.tx_tmr = fsp_tmr_next(s_ff.tx_tmr, s_ff.baud);
        end
        unique case (s_ff.tx_st)
            TX_IDLE: begin
                // Block start waits for a byte already on the line
                if (s_ff.tx_blk) begin
                    nxt_s.tx_st = TX_FETCH;
                end
            end
            TX_FETCH: begin
                // Receive writes own the memory port; fetch retries
                if (!nxt_s.mem.req) begin
                    nxt_s.mem.req  = 1'b1;
                    nxt_s.mem.addr = s_ff.tx_ptr;
                    nxt_s.tx_st    = TX_WAIT;
                end
            end
            TX_WAIT: begin
                nxt_s.tx_st = TX_LOAD;
            end
            TX_LOAD: begin
                nxt_s.tx_shift = mem_rdata;
                nxt_s.tx_st    = TX_START;
                nxt_s.tx_tmr   = s_ff.baud;
            end
            TX_START: begin
                if (tx_tick) begin
                    nxt_s.tx_st   = TX_DATA;
                    nxt_s.tx_bits = 8'h07;
                end
            end
            TX_DATA: begin
                if (tx_tick) begin
                    nxt_s.tx_shift = {1'b0, s_ff.tx_shift[7:1]};
                    nxt_s.tx_bits  = s_ff.tx_bits - 8'h01;
                    if (s_ff.tx_bits == 8'h00) begin
                        nxt_s.tx_st = TX_STOP;
                        if (s_ff.tx_blk) begin
                            nxt_s.tx_bits = gap_bits;
                        end else begin
                            nxt_s.tx_bits = s_ff.one_stop ? FSP_STOP_ONE : FSP_STOP_TWO;
                        end
                    end
                end
            end
            TX_STOP: begin
                if (tx_tick) begin
                    nxt_s.tx_bits = s_ff.tx_bits - 8'h01;
                    if (s_ff.tx_bits == 8'h01) begin
                        nxt_s.tx_st = TX_IDLE;
                        // Count and pointer move only once the stop bits are out
                        if (s_ff.tx_blk) begin
                            nxt_s.tx_ptr = s_ff.tx_ptr + 16'h0001;
                            nxt_s.tx_cnt = s_ff.tx_cnt - 10'h001;
                            if (s_ff.tx_cnt == FSP_CNT_RST) begin
                                nxt_s.tx_blk  = 1'b0;
                                nxt_s.tx_done = 1'b1;
                            end
                        end
                    end
                end
            end
            // Unused state code recovers to idle
            default: begin
                nxt_s.tx_st = TX_IDLE;
            end
        endcase
        nxt_s.tx_line = (nxt_s.tx_st == TX_START) ? 1'b0 :
                        (nxt_s.tx_st == TX_DATA) ? nxt_s.tx_shift[0] : 1'b1;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_ff         <= '0;
            s_ff.gap     <= FSP_GAP_RST;
            s_ff.baud    <= FSP_BAUD_RST;
            s_ff.rx_base <= FSP_ADDR_RST;
            s_ff.tx_base <= FSP_ADDR_RST;
            s_ff.rx_cnt  <= FSP_CNT_RST;
            s_ff.tx_cnt  <= FSP_CNT_RST;
            s_ff.tx_line <= 1'b1;
            s_ff.rx_s1   <= 1'b1;
            s_ff.rx_s2   <= 1'b1;
        end else if (ce) begin
            s_ff <= nxt_s;
        end
    end

endmodule : fsp_serial_port

// ===== sim/fsp_serial_port_sva.sv
`timescale 1ns/1ps
module fsp_chk
    import fsp_pkg::*;
(
    input wire logic        pclk,    // Clock
    input wire logic        presetn, // Reset, active low
    input wire logic        ce,      // Clock enable
    input wire logic        psel,    // APB select
    input wire logic        penable, // APB access
    input wire logic        pwrite,  // APB direction
    input wire logic [31:0] paddr,   // APB address
    input wire logic [31:0] prdata,  // APB read data
    input wire logic        pready,  // APB ready
    input wire logic        pslverr, // APB error
    input wire logic        txd,     // Serial out
    input wire fsp_mem_type mem_o    // Memory request
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic       rd;
    logic       mapped;
    logic       rdm;
    logic [2:0] sel;
    assign rd     = pready && !pwrite;
    assign mapped = paddr >= 32'h000301C0 && paddr <= 32'h000301F8 && paddr[2:0] == 3'h0;
    assign rdm    = rd && mapped;
    assign sel    = paddr[5:3];
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_ready_cause: assert property (pready |-> psel && penable && $past(psel) && $past(ce))
        else $error("pready without access phase");
    a_upper_zero: assert property (rd |-> prdata[31:16] == 16'h0000)
        else $error("read data upper half not zero");
    a_cnt_width: assert property (rdm && (sel == 3'h5 || sel == 3'h7) |->
        prdata[15:10] == 6'h00)
        else $error("counter read wider than ten bits");
    a_byte_width: assert property (rdm && (sel == 3'h2 || sel == 3'h3) |->
        prdata[15:8] == 8'h00)
        else $error("gap or data read wider than a byte");
    a_map_ok: assert property (pready && mapped |-> !pslverr)
        else $error("error on mapped register");
    a_unmap_err: assert property (pready && !mapped |-> pslverr)
        else $error("no error on unmapped address");
    a_mem_pulse: assert property (mem_o.req |=>
        !(mem_o.req && mem_o.we == $past(mem_o.we)))
        else $error("same memory request repeated");
    a_start_bit: assert property ($fell(txd) |-> !txd [*8])
        else $error("start bit too short");
    c_mem_wr: cover property (mem_o.req && mem_o.we);
    c_tx: cover property ($fell(txd));
    c_err: cover property (pready && pslverr);
endmodule : fsp_chk

bind fsp_serial_port fsp_chk u_chk (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .txd(txd), .mem_o(mem_o));

// ===== sim/fsp_peer.sv
`timescale 1ns/1ps
module fsp_peer #(
    parameter int BT = 24
) (
    input  wire logic clk, // Bench clock
    input  wire logic txd, // Line from the port
    output logic      rxd  // Line into the port
);
    logic [7:0] got;
    int         nrx = 0;
    int         run = 0;
    int         idle;
    initial rxd = 1'b1;
    // High time before each start bit, stop bits plus idle
    always @(posedge clk) run <= txd ? run + 1 : 0;
    // Last slot is the stop bit, which then stands as idle
    task automatic send(input logic [7:0] b);
        for (int i = 0; i < 10; i++) begin
            rxd <= (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : b[(i + 7) % 8];
            repeat (BT) @(posedge clk);
        end
    endtask : send
    initial forever begin
        @(negedge txd);
        idle = run;
        repeat (BT / 2) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            repeat (BT) @(posedge clk);
            got[i] = txd;
        end
        repeat (BT) @(posedge clk);
        nrx++;
    end
endmodule : fsp_peer

// ===== sim/testbench.sv
`timescale 1ns/1ps
module testbench;
    import fsp_pkg::*;
    typedef struct {logic w; logic [15:0] idx; logic [15:0] d; logic [15:0] x;} fsp_row_type;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, rxd, txd, ev;
    logic [31:0] paddr, pwdata, prdata, rv;
    logic [7:0]  mem_rdata;
    logic [7:0]  mem [0:255];
    fsp_mem_type mem_o;
    int          error_cnt, tests_run, n0;
    fsp_row_type rows [8] = '{
        '{1'b0, FSP_GAP_IDX, 16'h0000, 16'h0009},
        '{1'b0, FSP_RXBASE_IDX, 16'h0000, 16'h0000},
        '{1'b0, FSP_TXBASE_IDX, 16'h0000, 16'h0000},
        '{1'b0, FSP_BAUD_IDX, 16'h0000, 16'h0017},
        '{1'b0, FSP_TXCNT_IDX, 16'h0000, 16'h0000},
        '{1'b1, FSP_GAP_IDX, 16'h000C, 16'h000C},
        '{1'b1, FSP_RXBASE_IDX, 16'hABCD, 16'hABCD},
        '{1'b1, FSP_TXBASE_IDX, 16'h1234, 16'h1234}};
    fsp_serial_port uut (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .rxd(rxd), .txd(txd), .mem_o(mem_o),
        .mem_rdata(mem_rdata));
    fsp_peer #(.BT(int'(FSP_BAUD_RST) + 1)) peer (.clk(pclk), .txd(txd), .rxd(rxd));
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    // Released read bus toggles so stale data cannot pass
    always @(posedge pclk)
        if (mem_o.req && mem_o.we) mem[mem_o.addr[7:0]] <= mem_o.wdata;
        else if (mem_o.req) mem_rdata <= mem[mem_o.addr[7:0]];
        else mem_rdata <= ~mem_rdata;
    task automatic finish_test;
        $display("checks %0d, errors %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : finish_test
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [15:0] idx, input logic [15:0] d);
        int k;
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= {14'h0000, idx, 2'h0};
        pwdata <= {16'h0000, d};
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        rv = prdata;
        ev = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
        if (k >= 50) begin
            error_cnt++;
            finish_test();
        end
    endtask : apb
    task automatic poll(input int b);
        int k;
        for (k = 0; k < 3000; k++) begin
            apb(1'b0, FSP_CTRL_IDX, 16'h0000);
            if (rv[b] === 1'b1) break;
        end
        if (k >= 3000) begin
            error_cnt++;
            finish_test();
        end
    endtask : poll
    task automatic wait_rx(input int n);
        int k;
        for (k = 0; k < 20000 && peer.nrx < n; k++) @(posedge pclk);
        if (k >= 20000) begin
            error_cnt++;
            finish_test();
        end
    endtask : wait_rx
    initial begin
        presetn   = 1'b0;
        psel      = 1'b0;
        penable   = 1'b0;
        pwrite    = 1'b0;
        paddr     = 32'h00000000;
        pwdata    = 32'h00000000;
        mem_rdata = 8'h00;
        error_cnt = 0;
        tests_run = 0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        foreach (rows[i]) begin
            if (rows[i].w) apb(1'b1, rows[i].idx, rows[i].d);
            apb(1'b0, rows[i].idx, 16'h0000);
            chk(rv, {16'h0000, rows[i].x});
        end
        apb(1'b0, 16'hC080, 16'h0000);
        chk(ev, 1'b1);
        peer.send(8'hA5);
        poll(FSP_RXRDY_BIT);
        chk(rv[FSP_RXRDY_BIT], 1'b1);
        apb(1'b0, FSP_DATA_IDX, 16'h0000);
        chk(rv, 32'h000000A5);
        apb(1'b1, FSP_CTRL_IDX, 16'h0020);
        poll(FSP_TXRDY_BIT);
        apb(1'b1, FSP_DATA_IDX, 16'h003C);
        apb(1'b1, FSP_DATA_IDX, 16'h00C3);
        wait_rx(1);
        chk(peer.got, 8'h3C);
        poll(FSP_TXRDY_BIT);
        chk(peer.nrx, 1);
        apb(1'b1, FSP_RXBASE_IDX, 16'h0010);
        apb(1'b1, FSP_RXCNT_IDX, 16'h0002);
        for (int i = 0; i < 3; i++) begin
            peer.send(8'(8'h11 * (i + 1)));
            apb(1'b0, FSP_RXCNT_IDX, 16'h0000);
            chk(rv, 32'(1 - i) & 32'h000003FF);
        end
        apb(1'b0, FSP_CTRL_IDX, 16'h0000);
        chk(rv[FSP_RXDONE_BIT], 1'b1);
        for (int i = 0; i < 3; i++) chk(mem[8'h10 + i], 8'(8'h11 * (i + 1)));
        for (int i = 0; i < 3; i++) mem[8'h40 + i] = 8'(8'h40 + i);
        apb(1'b1, FSP_GAP_IDX, 16'h000A);
        apb(1'b1, FSP_TXBASE_IDX, 16'h0040);
        n0 = peer.nrx;
        apb(1'b1, FSP_TXCNT_IDX, 16'h0002);
        for (int i = 0; i < 3; i++) begin
            wait_rx(n0 + i + 1);
            chk(peer.got, 8'(8'h40 + i));
            if (i > 0) chk(peer.idle >= 72 && peer.idle <= 84, 1'b1);
        end
        poll(FSP_TXDONE_BIT);
        chk(rv[FSP_TXDONE_BIT], 1'b1);
        apb(1'b0, FSP_TXCNT_IDX, 16'h0000);
        chk(rv, 32'h000003FF);
        apb(1'b1, FSP_CTRL_IDX, 16'h00C0);
        apb(1'b0, FSP_CTRL_IDX, 16'h0000);
        chk(rv[FSP_TXDONE_BIT], 1'b0);
        chk(rv[FSP_RXDONE_BIT], 1'b0);
        chk(rv[FSP_ONESTOP_BIT], 1'b0);
        n0 = peer.nrx;
        poll(FSP_TXRDY_BIT);
        apb(1'b1, FSP_DATA_IDX, 16'h005A);
        poll(FSP_TXRDY_BIT);
        apb(1'b1, FSP_DATA_IDX, 16'h0096);
        wait_rx(n0 + 2);
        chk(peer.got, 8'h96);
        chk(peer.idle >= 48 && peer.idle < 72, 1'b1);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, FSP_GAP_IDX, 16'h0000);
        chk(rv, 32'h00000009);
        apb(1'b0, FSP_RXBASE_IDX, 16'h0000);
        chk(rv, 32'h00000000);
        apb(1'b0, FSP_TXBASE_IDX, 16'h0000);
        chk(rv, 32'h00000000);
        finish_test();
    end
endmodule : testbench
